// File: host_i2c_defines.vh
// constants for the serial host interface bus session controller
`ifndef HOST_I2C_DEFINES_VH
`define HOST_I2C_DEFINES_VH
`define WORD_W 24
`define WL_8 2'b00
`define WL_16 2'b01
`define REQ_OFF 2'b00
`define REQ_RX 2'b01
`define REQ_TX 2'b10
`define ACK_BIT 4'h8
`define LAST_DATA_BIT 4'h7
`define ADDR_FIXED 5'h0A
`define CLK_DIV_FLOOR 8'h04
`endif

// File: rx_word_fifo.v
// receive word fifo with valid and ready on both sides
`timescale 1ns/1ps
module rx_word_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_ni,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  // pointers wrap freely, so DEPTH must equal 2**AW
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_q];

  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // rx_word_fifo

// File: host_i2c_session_control.v
// two-wire bus session controller, slave and single master
`timescale 1ns/1ps
`include "host_i2c_defines.vh"
module host_i2c_session_control #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire interface_enable_i,
  input wire protocol_select_i,
  input wire master_select_i,
  input wire [1:0] word_length_select_i,
  input wire [1:0] request_line_mode_i,
  input wire idle_control_bit_i,
  input wire bus_error_irq_enable_i,
  input wire [7:0] clock_control_register_i,
  input wire clear_flags_i,
  input wire tx_write_i,
  input wire [`WORD_W-1:0] tx_data_i,
  input wire rx_read_i,
  output wire [`WORD_W-1:0] rx_data_o,
  output wire receive_not_empty_flag_o,
  output wire transmit_empty_flag_o,
  output wire receive_overrun_flag_o,
  output wire transmit_underrun_flag_o,
  output wire bus_error_flag_o,
  output wire bus_error_irq_o,
  output wire idle_status_o,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire host_request_n_i,
  output wire host_request_n_o,
  output wire host_request_oe_o,
  input wire address_pin_low_i,
  input wire address_pin_high_i
);
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_ADDR = 2'b01;
  localparam [1:0] S_RX = 2'b10;
  localparam [1:0] S_TX = 2'b11;
  localparam [3:0] M_IDLE = 4'h0;
  localparam [3:0] M_START = 4'h1;
  localparam [3:0] M_LOW = 4'h2;
  localparam [3:0] M_SETUP = 4'h3;
  localparam [3:0] M_HIGH = 4'h4;
  localparam [3:0] M_HOLD = 4'h5;
  localparam [3:0] M_WAIT = 4'h6;
  localparam [3:0] M_STOP1 = 4'h7;
  localparam [3:0] M_STOP2 = 4'h8;
  localparam [3:0] M_STOP3 = 4'h9;

  function [1:0] last_byte;
    input [1:0] wl;
    begin
      case (wl)
        `WL_8: last_byte = 2'd0;
        `WL_16: last_byte = 2'd1;
        default: last_byte = 2'd2;
      endcase
    end
  endfunction

  // received bytes collect at the bottom; words sit left-justified
  function [`WORD_W-1:0] align;
    input [`WORD_W-1:0] v;
    input [1:0] wl;
    begin
      case (wl)
        `WL_8: align = {v[7:0], 16'h0000};
        `WL_16: align = {v[15:0], 8'h00};
        default: align = v;
      endcase
    end
  endfunction

  reg [1:0] rst_sync_q;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_q[1];

  // pin order: addr high, addr low, request, data, clock
  wire [4:0] pins_raw = {address_pin_high_i, address_pin_low_i, host_request_n_i, sda_i, scl_i};
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg [1:0] prev_q;
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 5'h1F;
      sync2_q <= 5'h1F;
      prev_q <= 2'b11;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q[1:0];
    end
  end
  wire scl_s = sync2_q[0];
  wire sda_s = sync2_q[1];
  wire req_n_s = sync2_q[2];
  wire scl_rise = scl_s & ~prev_q[0];
  wire scl_fall = ~scl_s & prev_q[0];
  wire sda_rise = sda_s & ~prev_q[1];
  wire sda_fall = ~sda_s & prev_q[1];

  wire en = interface_enable_i & protocol_select_i;
  wire master_mode = en & master_select_i;
  wire slave_mode = en & ~master_select_i;
  wire [6:0] own_addr = {`ADDR_FIXED, sync2_q[4], sync2_q[3]};

  reg [1:0] st_q;
  reg [3:0] mst_q;
  reg [1:0] kind_q;
  reg m_rw_q;
  reg ack_q;
  reg scl_q;
  reg drive_q;
  reg [3:0] bit_q;
  reg [1:0] byte_q;
  reg [`WORD_W-1:0] io_shift_q;
  reg [`WORD_W-1:0] hold_q;
  reg hold_valid_q;
  reg [`WORD_W-1:0] last_word_q;
  reg overrun_q;
  reg underrun_q;
  reg bus_err_q;
  reg rx_busy_q;
  reg req_tx_q;
  reg push_q;
  reg [`WORD_W-1:0] push_data_q;
  reg [7:0] div_q;

  wire fifo_in_ready;
  wire [1:0] wl = word_length_select_i;
  wire word_done = (byte_q == last_byte(wl));
  wire addr_match = (io_shift_q[7:1] == own_addr);
  wire [`WORD_W-1:0] rx_next = {io_shift_q[`WORD_W-2:0], sda_s};
  wire tick = (div_q == 8'h00);
  wire [7:0] div_load = (clock_control_register_i < `CLK_DIV_FLOOR) ?
                        `CLK_DIV_FLOOR : clock_control_register_i;
  wire addr_write = master_mode & tx_write_i & idle_control_bit_i & (mst_q == M_IDLE);

  // divider runs in master mode only
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else if (!master_mode) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= div_load;
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      mst_q <= M_IDLE;
      kind_q <= S_IDLE;
      m_rw_q <= 1'b0;
      ack_q <= 1'b0;
      scl_q <= 1'b1;
      drive_q <= 1'b0;
      bit_q <= 4'h0;
      byte_q <= 2'd0;
      io_shift_q <= 24'h000000;
      hold_q <= 24'h000000;
      hold_valid_q <= 1'b0;
      last_word_q <= 24'h000000;
      overrun_q <= 1'b0;
      underrun_q <= 1'b0;
      bus_err_q <= 1'b0;
      rx_busy_q <= 1'b0;
      req_tx_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 24'h000000;
    end else if (!en) begin
      // individual reset: paths and status cleared
      st_q <= S_IDLE;
      mst_q <= M_IDLE;
      scl_q <= 1'b1;
      drive_q <= 1'b0;
      bit_q <= 4'h0;
      byte_q <= 2'd0;
      hold_valid_q <= 1'b0;
      overrun_q <= 1'b0;
      underrun_q <= 1'b0;
      bus_err_q <= 1'b0;
      rx_busy_q <= 1'b0;
      req_tx_q <= 1'b0;
      push_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      // clears come first so that a same-cycle set below wins
      if (clear_flags_i) begin
        overrun_q <= 1'b0;
        underrun_q <= 1'b0;
        bus_err_q <= 1'b0;
      end
      if (slave_mode) begin
        if (sda_fall & scl_s) begin
          st_q <= S_ADDR;
          bit_q <= 4'h0;
          drive_q <= 1'b0;
        end else if (sda_rise & scl_s) begin
          st_q <= S_IDLE;
          drive_q <= 1'b0;
          rx_busy_q <= 1'b0;
        end else if (scl_rise && st_q != S_IDLE) begin
          if (bit_q != `ACK_BIT) begin
            bit_q <= bit_q + 4'h1;
            if (st_q != S_TX) begin
              io_shift_q <= rx_next;
            end
            if (bit_q == 4'h0 && byte_q == 2'd0) begin
              if (st_q == S_RX) begin
                rx_busy_q <= 1'b1;
              end
              if (st_q == S_TX) begin
                req_tx_q <= 1'b0;
              end
            end
          end else begin
            bit_q <= 4'h0;
            case (st_q)
              S_ADDR: begin
                byte_q <= 2'd0;
                if (!addr_match) begin
                  st_q <= S_IDLE;
                end else if (io_shift_q[0]) begin
                  st_q <= S_TX;
                  if (hold_valid_q) begin
                    io_shift_q <= hold_q;
                    last_word_q <= hold_q;
                    hold_valid_q <= 1'b0;
                    req_tx_q <= 1'b1;
                  end else begin
                    io_shift_q <= last_word_q;
                    underrun_q <= 1'b1;
                  end
                end else begin
                  st_q <= S_RX;
                end
              end
              S_TX: begin
                if (sda_s) begin
                  st_q <= S_IDLE;
                end else if (word_done) begin
                  byte_q <= 2'd0;
                  if (hold_valid_q) begin
                    io_shift_q <= hold_q;
                    last_word_q <= hold_q;
                    hold_valid_q <= 1'b0;
                    req_tx_q <= 1'b1;
                  end else begin
                    io_shift_q <= last_word_q;
                    underrun_q <= 1'b1;
                  end
                end else begin
                  byte_q <= byte_q + 2'd1;
                end
              end
              default: begin
                st_q <= st_q;
              end
            endcase
          end
        end else if (scl_fall) begin
          if (bit_q == `ACK_BIT) begin
            case (st_q)
              S_ADDR: drive_q <= addr_match;
              S_RX: begin
                // no room for a finished word: refuse it and drop it
                drive_q <= ~(word_done & ~fifo_in_ready);
                byte_q <= word_done ? 2'd0 : byte_q + 2'd1;
                if (word_done) begin
                  rx_busy_q <= 1'b0;
                  if (fifo_in_ready) begin
                    push_q <= 1'b1;
                    push_data_q <= align(io_shift_q, wl);
                  end else begin
                    overrun_q <= 1'b1;
                  end
                end
              end
              default: drive_q <= 1'b0;
            endcase
          end else if (st_q == S_TX) begin
            drive_q <= ~io_shift_q[`WORD_W-1];
            io_shift_q <= {io_shift_q[`WORD_W-2:0], 1'b0};
          end else begin
            drive_q <= 1'b0;
          end
        end
      end else begin
        st_q <= S_IDLE;
        case (mst_q)
          M_IDLE: begin
            scl_q <= 1'b1;
            drive_q <= 1'b0;
            if (addr_write) begin
              io_shift_q <= {tx_data_i[23:16], 16'h0000};
              m_rw_q <= tx_data_i[16];
              kind_q <= S_ADDR;
              bit_q <= 4'h0;
              byte_q <= 2'd0;
              drive_q <= 1'b1;
              mst_q <= M_START;
            end
          end
          M_START: begin
            if (tick) begin
              scl_q <= 1'b0;
              mst_q <= M_LOW;
            end
          end
          M_LOW: begin
            if (tick) begin
              // the slave pulls its request away at the word's first clock
              if (bit_q == 4'h0 && byte_q == 2'd0 && kind_q != S_ADDR &&
                  request_line_mode_i != `REQ_OFF && req_n_s) begin
                mst_q <= M_LOW;
              end else begin
                mst_q <= M_SETUP;
                if (bit_q == `ACK_BIT) begin
                  drive_q <= (kind_q == S_RX) & ack_q;
                end else if (kind_q == S_RX) begin
                  drive_q <= 1'b0;
                end else begin
                  drive_q <= ~io_shift_q[`WORD_W-1];
                  io_shift_q <= {io_shift_q[`WORD_W-2:0], 1'b0};
                end
              end
            end
          end
          M_SETUP: begin
            if (tick) begin
              scl_q <= 1'b1;
              mst_q <= M_HIGH;
            end
          end
          M_HIGH: begin
            if (tick) begin
              scl_q <= 1'b0;
              mst_q <= M_LOW;
              if (bit_q != `ACK_BIT) begin
                bit_q <= bit_q + 4'h1;
                if (kind_q == S_RX) begin
                  io_shift_q <= rx_next;
                  if (bit_q == `LAST_DATA_BIT) begin
                    if (word_done & ~fifo_in_ready) begin
                      mst_q <= M_HOLD;
                    end else begin
                      ack_q <= ~(idle_control_bit_i & word_done);
                      if (word_done) begin
                        push_q <= 1'b1;
                        push_data_q <= align(rx_next, wl);
                      end
                    end
                  end
                end
              end else begin
                bit_q <= 4'h0;
                case (kind_q)
                  S_ADDR: begin
                    if (sda_s) begin
                      bus_err_q <= 1'b1;
                      mst_q <= M_STOP1;
                    end else if (m_rw_q) begin
                      kind_q <= S_RX;
                    end else begin
                      kind_q <= S_TX;
                      mst_q <= M_WAIT;
                    end
                  end
                  S_TX: begin
                    if (sda_s) begin
                      bus_err_q <= 1'b1;
                      mst_q <= M_STOP1;
                    end else if (word_done) begin
                      byte_q <= 2'd0;
                      mst_q <= M_WAIT;
                    end else begin
                      byte_q <= byte_q + 2'd1;
                    end
                  end
                  default: begin
                    byte_q <= word_done ? 2'd0 : byte_q + 2'd1;
                    if (!ack_q) begin
                      mst_q <= M_STOP1;
                    end
                  end
                endcase
              end
            end
          end
          M_HOLD: begin
            if (fifo_in_ready) begin
              ack_q <= 1'b1;
              push_q <= 1'b1;
              push_data_q <= align(io_shift_q, wl);
              mst_q <= M_LOW;
            end else if (idle_control_bit_i) begin
              ack_q <= 1'b0;
              mst_q <= M_LOW;
            end
          end
          M_WAIT: begin
            // clock held low until a word to send or idle arrives
            if (hold_valid_q) begin
              io_shift_q <= hold_q;
              hold_valid_q <= 1'b0;
              mst_q <= M_LOW;
            end else if (idle_control_bit_i) begin
              mst_q <= M_STOP1;
            end
          end
          M_STOP1: begin
            if (tick) begin
              drive_q <= 1'b1;
              mst_q <= M_STOP2;
            end
          end
          M_STOP2: begin
            if (tick) begin
              scl_q <= 1'b1;
              mst_q <= M_STOP3;
            end
          end
          M_STOP3: begin
            if (tick) begin
              drive_q <= 1'b0;
              mst_q <= M_IDLE;
            end
          end
          default: mst_q <= M_IDLE;
        endcase
      end
      // a new word outranks a same-cycle load of the old one
      if (tx_write_i && !addr_write) begin
        hold_q <= tx_data_i;
        hold_valid_q <= 1'b1;
      end
    end
  end

  rx_word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .clk_i(ref_clk_i),
    .rst_ni(rst_n),
    .flush_i(~en),
    .in_valid_i(push_q),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data_q),
    .out_valid_o(receive_not_empty_flag_o),
    .out_ready_i(rx_read_i),
    .out_data_o(rx_data_o)
  );

  wire req_rx_ok = ~rx_busy_q & fifo_in_ready;
  reg req_active;
  always @* begin
    case (request_line_mode_i)
      `REQ_RX: req_active = req_rx_ok;
      `REQ_TX: req_active = req_tx_q;
      `REQ_OFF: req_active = 1'b0;
      default: req_active = req_rx_ok & req_tx_q;
    endcase
  end

  assign host_request_n_o = ~req_active;
  assign host_request_oe_o = slave_mode;
  assign scl_o = scl_q;
  assign scl_oe_o = master_mode;
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_q;
  assign transmit_empty_flag_o = ~hold_valid_q;
  assign receive_overrun_flag_o = overrun_q;
  assign transmit_underrun_flag_o = underrun_q;
  assign bus_error_flag_o = bus_err_q;
  assign bus_error_irq_o = bus_err_q & bus_error_irq_enable_i;
  assign idle_status_o = master_mode ? (mst_q == M_IDLE) : (st_q == S_IDLE);
endmodule // host_i2c_session_control

// File: host_i2c_session_sva.sv
// assertion checker for the two-wire session controller ports
`timescale 1ns/1ps
module host_i2c_session_sva #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire interface_enable_i,
  input wire protocol_select_i,
  input wire master_select_i,
  input wire [1:0] request_line_mode_i,
  input wire bus_error_irq_enable_i,
  input wire clear_flags_i,
  input wire tx_write_i,
  input wire rx_read_i,
  input wire [23:0] rx_data_o,
  input wire receive_not_empty_flag_o,
  input wire transmit_empty_flag_o,
  input wire receive_overrun_flag_o,
  input wire bus_error_flag_o,
  input wire bus_error_irq_o,
  input wire scl_oe_o,
  input wire sda_o,
  input wire host_request_n_o,
  input wire host_request_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  wire slv = interface_enable_i && protocol_select_i && !master_select_i;
  wire mst = interface_enable_i && protocol_select_i && master_select_i;
  AST_IRQ_FOLLOWS: assert property (bus_error_irq_o == (bus_error_flag_o && bus_error_irq_enable_i))
    else $error("irq does not follow bus error flag");
  AST_MASTER_PINS: assert property (mst && $past(mst) && $past(mst, 2) |-> scl_oe_o && !host_request_oe_o)
    else $error("master pin directions wrong");
  AST_SLAVE_PINS: assert property (slv && $past(slv) && $past(slv, 2) |-> !scl_oe_o && host_request_oe_o)
    else $error("slave pin directions wrong");
  AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  AST_REQ_OFF: assert property (slv && request_line_mode_i == 2'b00 |-> host_request_n_o)
    else $error("request asserted while disabled");
  AST_WRITE_FILLS: assert property (slv && tx_write_i |=> !transmit_empty_flag_o)
    else $error("write left holding register empty");
  AST_EMPTY_CAUSE: assert property ($fell(transmit_empty_flag_o) |-> $past(tx_write_i))
    else $error("empty flag fell without a write");
  AST_NOT_EMPTY_HOLDS: assert property (receive_not_empty_flag_o && !rx_read_i && interface_enable_i
    |=> receive_not_empty_flag_o && $stable(rx_data_o))
    else $error("fifo head lost without a read");
  AST_OVERRUN_STICKY: assert property (receive_overrun_flag_o && !clear_flags_i && interface_enable_i
    |=> receive_overrun_flag_o)
    else $error("overrun flag dropped");
  AST_BER_MASTER: assert property ($rose(bus_error_flag_o) |-> mst)
    else $error("bus error outside master mode");
  cover property ($rose(receive_overrun_flag_o));
  cover property ($rose(bus_error_flag_o));
  cover property ($fell(host_request_n_o));
endmodule // host_i2c_session_sva

bind host_i2c_session_control host_i2c_session_sva #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW))
  u_sva (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .interface_enable_i(interface_enable_i),
    .protocol_select_i(protocol_select_i), .master_select_i(master_select_i),
    .request_line_mode_i(request_line_mode_i), .bus_error_irq_enable_i(bus_error_irq_enable_i),
    .clear_flags_i(clear_flags_i), .tx_write_i(tx_write_i), .rx_read_i(rx_read_i),
    .rx_data_o(rx_data_o), .receive_not_empty_flag_o(receive_not_empty_flag_o),
    .transmit_empty_flag_o(transmit_empty_flag_o),
    .receive_overrun_flag_o(receive_overrun_flag_o), .bus_error_flag_o(bus_error_flag_o),
    .bus_error_irq_o(bus_error_irq_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
    .host_request_n_o(host_request_n_o), .host_request_oe_o(host_request_oe_o));

// File: i2c_master_model.sv
// behavioural two-wire bus master driving link clock and data
`timescale 1ns/1ps
module i2c_master_model (
  input wire sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start;
    sda_low_o = 1'b0;
    #16 scl_o = 1'b1;
    #16 sda_low_o = 1'b1;
    #32 scl_o = 1'b0;
  endtask
  task automatic stop;
    #16 sda_low_o = 1'b1;
    #16 scl_o = 1'b1;
    #32 sda_low_o = 1'b0;
    #32;
  endtask
  // stands in for an addressed slave that reads as all zeros
  task automatic hold_low(input logic v);
    sda_low_o = v;
  endtask
  // ninth slot carries our ack; released line reads back the slave's answer
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic [8:0] bits;
    bits = {tx, mack};
    for (int i = 8; i >= 0; i--) begin
      #16 sda_low_o = !bits[i];
      #16 scl_o = 1'b1;
      #16 if (i > 0) rx[i-1] = sda_i; else ack = sda_i;
      #16 scl_o = 1'b0;
    end
  endtask
endmodule // i2c_master_model

// File: host_i2c_session_control_bench.sv
// self-checking bench for the two-wire session controller
`timescale 1ns/1ps
`include "host_i2c_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s expected %h seen %h", n, e, g); end end
module host_i2c_session_control_bench;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic en = 1'b0, mst = 1'b0, idle = 1'b0, clr = 1'b0, wr = 1'b0, rd = 1'b0, irq_en = 1'b1;
  logic host_request_line_n = 1'b1;
  logic [1:0] wl = 2'b00, rq = 2'b00;
  logic [23:0] wdata = 24'h000000;
  logic [23:0] rx_data;
  logic rne, tde, rovf, tund, ber, birq, idle_st, ack, acc;
  logic scl_o, scl_oe, sda_o, sda_oe, req_n, req_oe, m_scl, m_sda_low;
  logic [7:0] rb;
  int miscompares = 0, check_count = 0, cycles = 0, rises = 0;
  // pull-up on the data line; clock taken from whichever side drives it
  wire sda_bus = !(sda_oe || m_sda_low);
  wire scl_bus = scl_oe ? scl_o : m_scl;
  host_i2c_session_control DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .interface_enable_i(en), .protocol_select_i(1'b1), .master_select_i(mst),
    .word_length_select_i(wl), .request_line_mode_i(rq), .idle_control_bit_i(idle),
    .bus_error_irq_enable_i(irq_en), .clock_control_register_i(8'h04), .clear_flags_i(clr),
    .tx_write_i(wr), .tx_data_i(wdata), .rx_read_i(rd), .rx_data_o(rx_data),
    .receive_not_empty_flag_o(rne), .transmit_empty_flag_o(tde), .receive_overrun_flag_o(rovf),
    .transmit_underrun_flag_o(tund), .bus_error_flag_o(ber), .bus_error_irq_o(birq),
    .idle_status_o(idle_st), .scl_i(scl_bus), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_o(sda_oe), .host_request_n_i(host_request_line_n),
    .host_request_n_o(req_n), .host_request_oe_o(req_oe), .address_pin_low_i(1'b0),
    .address_pin_high_i(1'b1));
  i2c_master_model partner (.sda_i(sda_bus), .scl_o(m_scl), .sda_low_o(m_sda_low));
  always #2.5 ref_clk_i = !ref_clk_i;
  always @(posedge scl_bus) rises++;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      summarize();
    end
  end
  task summarize;
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic setup(input logic m, input logic [1:0] w, input logic [1:0] r);
    @(negedge ref_clk_i);
    en = 1'b0;
    @(negedge ref_clk_i);
    mst = m;
    wl = w;
    rq = r;
    en = 1'b1;
    repeat (6) @(negedge ref_clk_i);
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk_i);
    s = 1'b1;
    @(negedge ref_clk_i);
    s = 1'b0;
  endtask
  task automatic test_reset;
    `CHK("tx empty", 1'b1, tde)
    `CHK("rx not empty", 1'b0, rne)
    `CHK("flags", 3'b000, {rovf, tund, ber})
  endtask
  task automatic test_address;
    setup(1'b0, `WL_8, `REQ_OFF);
    partner.start();
    partner.xfer({7'h2B, 1'b0}, 1'b1, rb, ack);
    `CHK("foreign ack", 1'b1, ack)
    partner.start();
    partner.xfer({7'h2A, 1'b0}, 1'b1, rb, ack);
    `CHK("own ack", 1'b0, ack)
    partner.stop();
  endtask
  task automatic test_rx16;
    setup(1'b0, `WL_16, `REQ_RX);
    `CHK("rx request", 1'b0, req_n)
    wdata = 24'h777777;
    pulse(wr);
    partner.start();
    partner.xfer({7'h2A, 1'b0}, 1'b1, rb, acc);
    partner.xfer(8'hA5, 1'b1, rb, ack);
    acc = acc | ack;
    partner.xfer(8'h3C, 1'b1, rb, ack);
    `CHK("rx acks", 1'b0, acc | ack)
    partner.stop();
    `CHK("rx word", 24'hA53C00, rx_data)
    `CHK("tx kept", 1'b0, tde)
    `CHK("not empty", 1'b1, rne)
    pulse(rd);
    `CHK("drained", 1'b0, rne)
  endtask
  task automatic test_overrun;
    setup(1'b0, `WL_8, `REQ_RX);
    partner.start();
    partner.xfer({7'h2A, 1'b0}, 1'b1, rb, acc);
    for (int i = 0; i < 8; i++) begin
      partner.xfer(8'h10 + 8'(i), 1'b1, rb, ack);
      acc = acc | ack;
    end
    `CHK("fill acks", 1'b0, acc)
    `CHK("full request", 1'b1, req_n)
    partner.xfer(8'hEE, 1'b1, rb, ack);
    `CHK("overrun ack", 1'b1, ack)
    partner.stop();
    `CHK("overrun flag", 1'b1, rovf)
    for (int i = 0; i < 8; i++) begin
      `CHK("fifo word", {8'h10 + 8'(i), 16'h0000}, rx_data)
      pulse(rd);
    end
    `CHK("fifo empty", 1'b0, rne)
    pulse(clr);
    `CHK("overrun clear", 1'b0, rovf)
  endtask
  task automatic test_tx;
    setup(1'b0, `WL_8, `REQ_TX);
    wdata = 24'h3C5A00;
    pulse(wr);
    `CHK("tx held", 1'b0, tde)
    partner.start();
    partner.xfer({7'h2A, 1'b1}, 1'b1, rb, ack);
    `CHK("read ack", 1'b0, ack)
    `CHK("tx loaded", 1'b1, tde)
    `CHK("tx request", 1'b0, req_n)
    partner.xfer(8'hFF, 1'b0, rb, ack);
    `CHK("tx byte", 8'h3C, rb)
    `CHK("tx request off", 1'b1, req_n)
    partner.xfer(8'hFF, 1'b1, rb, ack);
    `CHK("resent byte", 8'h3C, rb)
    `CHK("underrun", 1'b1, tund)
    repeat (8) @(negedge ref_clk_i);
    `CHK("released", 1'b0, sda_oe)
    partner.stop();
  endtask
  task automatic test_master;
    setup(1'b1, `WL_8, `REQ_OFF);
    idle = 1'b1;
    `CHK("master pins", 2'b10, {scl_oe, req_oe})
    rises = 0;
    wdata = {7'h55, 1'b0, 16'hFFFF};
    pulse(wr);
    `CHK("busy", 1'b0, idle_st)
    for (int n = 0; n < 1000 && idle_st !== 1'b1; n++) @(negedge ref_clk_i);
    `CHK("nack error", 2'b11, {ber, birq})
    `CHK("clock pulses", 10, rises)
    idle = 1'b0;
  endtask
  task automatic test_master_rx;
    setup(1'b1, `WL_8, `REQ_RX);
    idle = 1'b1;
    partner.hold_low(1'b1);
    rises = 0;
    wdata = {7'h55, 1'b1, 16'h0000};
    pulse(wr);
    idle = 1'b0;
    repeat (400) @(negedge ref_clk_i);
    `CHK("paced pulses", 9, rises)
    host_request_line_n = 1'b0;
    repeat (1400) @(negedge ref_clk_i);
    `CHK("stall pulses", 89, rises)
    `CHK("rx head", 24'h000000, rx_data)
    `CHK("no errors", 2'b00, {rovf, ber})
    partner.hold_low(1'b0);
    idle = 1'b1;
    for (int n = 0; n < 200 && idle_st !== 1'b1; n++) @(negedge ref_clk_i);
    `CHK("stop pulses", 91, rises)
    `CHK("words kept", 1'b1, rne)
    idle = 1'b0;
  endtask
  initial begin
    repeat (5) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    test_reset();
    test_address();
    test_rx16();
    test_overrun();
    test_tx();
    test_master();
    test_master_rx();
    summarize();
  end
endmodule // host_i2c_session_control_bench
